// *** hs_port_pkg.sv ***
/*
 * Constants for the handshake parallel port: register offsets, field
 * positions, reset values and window decode.
 * Assumes a byte-wide processor bus with a 16-bit address.
 */
package hs_port_pkg;

    // ********************************************************************
    // Decode
    // ********************************************************************
    localparam logic [15:0] BASE_ADDR_ZERO = 16'h7e10;
    localparam int          WINDOW_BYTES   = 4;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 8;

    // ********************************************************************
    // Register offsets inside one window
    // ********************************************************************
    localparam logic [1:0] OFF_DATA = 2'h0;
    localparam logic [1:0] OFF_PULL = 2'h1;
    localparam logic [1:0] OFF_DIR  = 2'h2;
    localparam logic [1:0] OFF_CTRL = 2'h3;

    // ********************************************************************
    // Control/status field positions
    // ********************************************************************
    localparam int BIT_IRQ_FLAG   = 7;
    localparam int BIT_IN_LEVEL   = 6;
    localparam int BIT_IRQ_EN     = 5;
    localparam int BIT_TEST       = 4;
    localparam int BIT_OUT_LEVEL  = 1;
    localparam int BIT_EDGE_SEL   = 0;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_PULL = 8'hff;
    localparam logic [7:0] RST_DIR  = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h02;

    // ********************************************************************
    // Buffering
    // ********************************************************************
    localparam int FIFO_DEPTH = 16;

endpackage : hs_port_pkg

// *** hs_sync_edge.sv ***
/*
 * Two-flop synchroniser with rise and fall detection on the synced level.
 * Assumes one clock domain; the input may change at any time.
 */
`timescale 1ns/1ps
`default_nettype none

module hs_sync_edge (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    logic meta_next;
    logic sync_next;
    logic last_next;

    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    // Reset to high: an idle line is high, so no false edge after reset
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
    assign fall_o  = ~sync_reg & last_reg;

endmodule : hs_sync_edge
`default_nettype wire

// *** hs_fifo.sv ***
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and a single clock.
 */
`timescale 1ns/1ps
`default_nettype none

module hs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr_reg;
    logic [AW:0]      rptr_reg;
    logic [AW:0]      wptr_next;
    logic [AW:0]      rptr_next;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    // ********************************************************************
    // Pointers
    // ********************************************************************
    always_comb begin
        empty     = (wptr_reg == rptr_reg);
        full      = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) &&
                    (wptr_reg[AW] != rptr_reg[AW]);
        push      = in_valid_i & ~full;
        pop       = out_ready_i & ~empty;
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = pop  ? rptr_reg + 1'b1 : rptr_reg;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
        end
    end

    // Storage carries no reset; only pointers define validity
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = mem[rptr_reg[AW-1:0]];

endmodule : hs_fifo
`default_nettype wire

// *** hs_parallel_port.sv ***
/*
 * One instance of the 8-bit handshake parallel port with its four byte
 * registers: data, pull-up enable, direction and control/status.
 * Assumes a byte-wide processor bus with single-cycle read and write
 * strobes on mclk_i; the pad ring resolves the data pin enables.
 */
// Function
// - Eight bidirectional data lines, each independently set input or output.
// - Partner strobes inbound data on handshake_in; the port captures it then.
// - Port signals outbound data to the partner on handshake_out.
// - Status bit 7 sets on the selected handshake_in edge and holds until a status read clears it.
// - Status bit 6 shows the present handshake_in level.
// - Control bit 5 enables the interrupt; clear means no interrupt raised.
// - Control bit 4 loops handshake_out back into handshake_in.
// - Bits 3 and 2 read zero; fields flag, level, enable, test, out level, edge.
// - Each instance decodes four bytes from 0x7e10 onward, contiguously.
// - Control bit 1 sets the handshake_out level; low is active.
// - Control bit 0 picks rising (1) or falling (0) edge.
// - Direction bit 1 makes its line an output, 0 an input.
`timescale 1ns/1ps
`default_nettype none

module hs_parallel_port #(
    parameter int INSTANCE   = 0,
    parameter int FIFO_WIDTH = hs_port_pkg::DATA_W,
    parameter int FIFO_DEPTH = hs_port_pkg::FIFO_DEPTH
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Processor bus
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // Data pins
    input  wire logic [7:0]  pio_i,
    output logic      [7:0]  pio_o,
    output logic      [7:0]  pio_oe_o,
    output logic      [7:0]  pullup_en_o,
    // Handshake pins
    input  wire logic        handshake_in_i,
    output logic             handshake_out_o,
    output logic             rx_ready_o,
    // Interrupt request
    output logic             irq_o
);

    // ********************************************************************
    // Address decode
    // ********************************************************************
    localparam logic [15:0] BASE_ADDR =
        16'(hs_port_pkg::BASE_ADDR_ZERO +
            INSTANCE * hs_port_pkg::WINDOW_BYTES);

    logic       hit;
    logic       wr_hit;
    logic       rd_hit;
    logic [1:0] offset;

    always_comb begin
        hit    = (addr_i[15:2] == BASE_ADDR[15:2]);
        offset = addr_i[1:0];
        wr_hit = wr_i & hit;
        rd_hit = rd_i & hit;
    end

    // ********************************************************************
    // Handshake input path
    // ********************************************************************
    logic test_reg;
    logic out_level_reg;
    logic hs_in_mux;
    logic hs_in_level;
    logic hs_in_rise;
    logic hs_in_fall;
    logic edge_sel_reg;
    logic hs_event;

    // Loopback taken before the synchroniser so test mode sees the same
    // two-cycle latency as a real partner
    assign hs_in_mux = test_reg ? out_level_reg : handshake_in_i;

    hs_sync_edge u_sync (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .async_i     (hs_in_mux),
        .level_o     (hs_in_level),
        .rise_o      (hs_in_rise),
        .fall_o      (hs_in_fall)
    );

    assign hs_event = edge_sel_reg ? hs_in_rise : hs_in_fall;

    // ********************************************************************
    // Inbound buffer
    // ********************************************************************
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       fifo_pop;
    logic [7:0] dir_reg;
    logic [7:0] capture;

    // Only lines set as inputs carry partner data
    assign capture  = pio_i & ~dir_reg;
    assign fifo_pop = rd_hit & (offset == hs_port_pkg::OFF_DATA);

    hs_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (hs_event),
        .in_data_i   (capture),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop)
    );

    // Partner must hold off strobing while this is low; a strobe while
    // full is dropped but still sets the flag
    assign rx_ready_o = fifo_in_ready;

    // ********************************************************************
    // Port registers
    // ********************************************************************
    logic [7:0] data_reg;
    logic [7:0] pull_reg;
    logic [7:0] data_next;
    logic [7:0] pull_next;
    logic [7:0] dir_next;

    always_comb begin
        data_next = data_reg;
        pull_next = pull_reg;
        dir_next  = dir_reg;
        if (wr_hit) begin
            case (offset)
                hs_port_pkg::OFF_DATA: begin
                    data_next = wdata_i;
                end
                hs_port_pkg::OFF_PULL: begin
                    pull_next = wdata_i;
                end
                hs_port_pkg::OFF_DIR: begin
                    dir_next = wdata_i;
                end
                default: begin
                    data_next = data_reg;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            data_reg <= hs_port_pkg::RST_DATA;
            pull_reg <= hs_port_pkg::RST_PULL;
            dir_reg  <= hs_port_pkg::RST_DIR;
        end else begin
            data_reg <= data_next;
            pull_reg <= pull_next;
            dir_reg  <= dir_next;
        end
    end

    // ********************************************************************
    // Control fields
    // ********************************************************************
    logic irq_en_reg;
    logic irq_en_next;
    logic test_next;
    logic out_level_next;
    logic edge_sel_next;
    logic ctrl_write;

    // Bits 7, 6, 3 and 2 take no write data, so writes to them are lost
    always_comb begin
        ctrl_write     = wr_hit & (offset == hs_port_pkg::OFF_CTRL);
        irq_en_next    = irq_en_reg;
        test_next      = test_reg;
        out_level_next = out_level_reg;
        edge_sel_next  = edge_sel_reg;
        if (ctrl_write) begin
            irq_en_next    = wdata_i[hs_port_pkg::BIT_IRQ_EN];
            test_next      = wdata_i[hs_port_pkg::BIT_TEST];
            out_level_next = wdata_i[hs_port_pkg::BIT_OUT_LEVEL];
            edge_sel_next  = wdata_i[hs_port_pkg::BIT_EDGE_SEL];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_reg    <= hs_port_pkg::RST_CTRL[hs_port_pkg::BIT_IRQ_EN];
            test_reg      <= hs_port_pkg::RST_CTRL[hs_port_pkg::BIT_TEST];
            out_level_reg <=
                hs_port_pkg::RST_CTRL[hs_port_pkg::BIT_OUT_LEVEL];
            edge_sel_reg  <=
                hs_port_pkg::RST_CTRL[hs_port_pkg::BIT_EDGE_SEL];
        end else begin
            irq_en_reg    <= irq_en_next;
            test_reg      <= test_next;
            out_level_reg <= out_level_next;
            edge_sel_reg  <= edge_sel_next;
        end
    end

    // ********************************************************************
    // Event flag
    // ********************************************************************
    logic flag_reg;
    logic flag_next;
    logic status_read;

    // Read of the status clears the flag; a new edge in that same
    // cycle wins so no event is lost
    always_comb begin
        status_read = rd_hit & (offset == hs_port_pkg::OFF_CTRL);
        flag_next   = flag_reg;
        if (status_read) begin
            flag_next = 1'b0;
        end
        if (hs_event) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_reg <= hs_port_pkg::RST_CTRL[hs_port_pkg::BIT_IRQ_FLAG];
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ********************************************************************
    // Read data
    // ********************************************************************
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] status;
    logic [7:0] pin_view;

    always_comb begin
        status = 8'h00;
        status[hs_port_pkg::BIT_IRQ_FLAG]  = flag_reg;
        status[hs_port_pkg::BIT_IN_LEVEL]  = hs_in_level;
        status[hs_port_pkg::BIT_IRQ_EN]    = irq_en_reg;
        status[hs_port_pkg::BIT_TEST]      = test_reg;
        status[hs_port_pkg::BIT_OUT_LEVEL] = out_level_reg;
        status[hs_port_pkg::BIT_EDGE_SEL]  = edge_sel_reg;
    end

    // Output lines read back what is driven, input lines read the pin
    assign pin_view = (data_reg & dir_reg) | (pio_i & ~dir_reg);

    // Data stands one cycle only; an idle or unmapped bus reads zero
    always_comb begin
        rdata_next = 8'h00;
        if (rd_hit) begin
            case (offset)
                hs_port_pkg::OFF_DATA: begin
                    // Buffered inbound bytes come first, live pins after
                    rdata_next = fifo_out_valid ? fifo_out_data : pin_view;
                end
                hs_port_pkg::OFF_PULL: begin
                    rdata_next = pull_reg;
                end
                hs_port_pkg::OFF_DIR: begin
                    rdata_next = dir_reg;
                end
                hs_port_pkg::OFF_CTRL: begin
                    rdata_next = status;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign rdata_o         = rdata_reg;
    assign pio_o           = data_reg;
    assign pio_oe_o        = dir_reg;
    assign pullup_en_o     = pull_reg;
    // Pin keeps its level in test mode too; partner still sees strobes
    assign handshake_out_o = out_level_reg;
    assign irq_o           = flag_reg & irq_en_reg;

endmodule : hs_parallel_port
`default_nettype wire

// *** hs_port_assertions.sv ***
/* Checker for the handshake port: bus decode, pins and flag timing.
   Bound to hs_parallel_port; sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module hs_port_assertions #(
    parameter int INSTANCE = 0
) (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic [7:0]  pio_o,
    input wire logic [7:0]  pio_oe_o,
    input wire logic        handshake_in_i,
    input wire logic        handshake_out_o,
    input wire logic        irq_o
);
    // ****************
    // Decode and quiet counter
    // ****************
    localparam logic [15:0] BASE = hs_port_pkg::BASE_ADDR_ZERO
                                   + 16'(4 * INSTANCE);
    logic       hit;
    logic       rd_ctrl;
    logic       wr_ctrl;
    logic       hs_last_reg;
    logic [3:0] quiet_reg;
    logic [3:0] quiet_next;
    assign hit     = addr_i[15:2] == BASE[15:2];
    assign rd_ctrl = rd_i && hit && addr_i[1:0] == hs_port_pkg::OFF_CTRL;
    assign wr_ctrl = wr_i && hit && addr_i[1:0] == hs_port_pkg::OFF_CTRL;
    // Quiet means no pin change and no write, so no event can be in flight
    always_comb begin
        quiet_next = quiet_reg + {3'h0, quiet_reg != 4'hf};
        if (wr_i || handshake_in_i != hs_last_reg) begin
            quiet_next = 4'h0;
        end
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            quiet_reg   <= 4'h0;
            hs_last_reg <= 1'b1;
        end else begin
            quiet_reg   <= quiet_next;
            hs_last_reg <= handshake_in_i;
        end
    end
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_data_drive: assert property (
        wr_i && hit && addr_i[1:0] == hs_port_pkg::OFF_DATA
        |=> pio_o == $past(wdata_i)) else $error("pins miss data write");
    a_dir_enable: assert property (
        wr_i && hit && addr_i[1:0] == hs_port_pkg::OFF_DIR
        |=> pio_oe_o == $past(wdata_i)) else $error("enables miss dir write");
    a_out_level: assert property (
        wr_ctrl |=> handshake_out_o == $past(wdata_i[1]))
        else $error("handshake out misses control write");
    a_reserved_zero: assert property (
        rd_ctrl |=> rdata_o[3:2] == 2'h0) else $error("bits 3:2 not zero");
    a_unmapped_zero: assert property (
        rd_i && !hit |=> rdata_o == 8'h00) else $error("unmapped read data");
    a_irq_gate: assert property (
        rd_ctrl && !wr_i |=> $past(irq_o) == (rdata_o[7] && rdata_o[5]))
        else $error("irq differs from flag and enable");
    a_level_status: assert property (
        (handshake_in_i == handshake_out_o && $stable(handshake_in_i)
         && $stable(handshake_out_o))[*4] ##0 rd_ctrl
        |=> rdata_o[6] == $past(handshake_in_i)) else $error("level bit");
    a_irq_cause: assert property (
        $rose(irq_o) |-> quiet_reg < 4'h8) else $error("irq without cause");
    a_read_clears: assert property (
        rd_ctrl && !wr_i && quiet_reg > 4'h9 |=> !irq_o)
        else $error("status read did not clear flag");
    c_irq_rise: cover property ($rose(irq_o));
    c_flag_read: cover property (rd_ctrl ##1 rdata_o[7]);
    c_loopback: cover property (wr_ctrl && wdata_i[4]);
endmodule : hs_port_assertions
`default_nettype wire

// *** hs_peer.sv ***
/* Handshake peer: presents a byte, strobes handshake low, releases.
   Driven by task calls from the bench; uses the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module hs_peer (
    input  wire logic       mclk_i,
    output logic            hs_o,
    output logic      [7:0] d_o,
    output logic            d_oe_o
);
    // ****************
    // Strobe sequence
    // ****************
    initial begin
        hs_o   = 1'b1;
        d_o    = 8'h00;
        d_oe_o = 1'b0;
    end
    // Hold of 3 or more cycles on the low level only; data stays 5 cycles after the rise, the high level lasts at least 8 between calls; slow peers pass a larger hold
    task automatic send(input logic [7:0] b, input int hold);
        @(negedge mclk_i);
        d_o    = b;
        d_oe_o = 1'b1;
        repeat (2) @(negedge mclk_i);
        hs_o = 1'b0;
        repeat (hold) @(negedge mclk_i);
        hs_o = 1'b1;
        repeat (5) @(negedge mclk_i);
        d_oe_o = 1'b0;
        // Released lines never keep the last byte
        d_o    = ~b;
    endtask : send
endmodule : hs_peer
`default_nettype wire

// *** hs_parallel_port_tb_top.sv ***
/* Self-checking bench for hs_parallel_port with the peer model.
   Assumes the package, design, checker and peer are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module hs_parallel_port_tb_top;
    localparam logic [15:0] A = hs_port_pkg::BASE_ADDR_ZERO;
    logic        mclk_i  = 1'b0;
    logic        rst_i   = 1'b1;
    logic [15:0] addr_i  = 16'h0000;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic [7:0]  rdata_o, pio_i, pio_o, pio_oe_o, pullup_en_o, pd;
    logic        handshake_in, handshake_out, poe, rx_ready_o, irq_o;
    int          err_count   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    // ****************
    // Environment
    // ****************
    always #12.5 mclk_i = ~mclk_i;
    // Undriven lines sit at the pull-up level, else at the peer's junk
    assign pio_i = (pio_oe_o & pio_o)
                 | (~pio_oe_o & (poe ? pd : (pullup_en_o | pd)));
    hs_parallel_port hs_parallel_port_inst (
        .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .pio_i, .pio_o, .pio_oe_o, .pullup_en_o, .handshake_in_i(handshake_in),
        .handshake_out_o(handshake_out), .rx_ready_o, .irq_o);
    hs_peer hs_peer_inst (.mclk_i, .hs_o(handshake_in), .d_o(pd), .d_oe_o(poe));
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    // ****************
    // Shared tasks
    // ****************
    task automatic end_of_test;
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_i  = a;
        wdata_i = d;
        wr_i    = 1'b1;
        @(negedge mclk_i);
        wr_i = 1'b0;
    endtask : wr
    task automatic rc(input logic [15:0] a, input string n,
                      input logic [7:0] e);
        @(negedge mclk_i);
        addr_i = a;
        rd_i   = 1'b1;
        @(negedge mclk_i);
        rd_i = 1'b0;
        chk(n, e, rdata_o);
    endtask : rc
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        rc(A + 16'h3, "ctrl", hs_port_pkg::RST_CTRL | 8'h40);
        rc(A + 16'h2, "dir", 8'h00);
        rc(A + 16'h1, "pull", 8'hff);
        chk("hso", 8'h01, {7'h0, handshake_out});
    endtask : t_reset
    task automatic t_dir;
        wr(A + 16'h2, 8'hf0);
        wr(A, 8'ha5);
        chk("oe", 8'hf0, pio_oe_o);
        chk("pio", 8'ha5, pio_o);
        rc(A, "pins", 8'haf);
        wr(A + 16'h2, 8'h00);
        wr(A + 16'h6, 8'hff);
        chk("oe", 8'h00, pio_oe_o);
        rc(A + 16'h7, "next window", 8'h00);
        rc(A - 16'h1, "below", 8'h00);
        wr(A + 16'h1, 8'h0f);
        chk("pullup", 8'h0f, pullup_en_o);
        rc(A + 16'h1, "pull", 8'h0f);
        rc(A, "pulled pins", 8'h0f);
        wr(A + 16'h1, 8'hff);
        chk("pullup", 8'hff, pullup_en_o);
    endtask : t_dir
    task automatic t_falling;
        wr(A + 16'h3, 8'h22);
        hs_peer_inst.send(8'h3c, 3);
        repeat (6) @(negedge mclk_i);
        chk("irq", 8'h01, {7'h0, irq_o});
        rc(A + 16'h3, "flag", 8'he2);
        rc(A, "rx byte", 8'h3c);
        rc(A + 16'h3, "cleared", 8'h62);
        chk("irq", 8'h00, {7'h0, irq_o});
    endtask : t_falling
    task automatic t_rising;
        wr(A + 16'h3, 8'h03);
        hs_peer_inst.send(8'h99, 8);
        repeat (4) @(negedge mclk_i);
        chk("irq", 8'h00, {7'h0, irq_o});
        rc(A + 16'h3, "flag", 8'hc3);
        rc(A + 16'h3, "once", 8'h43);
        rc(A, "rx byte", 8'h99);
    endtask : t_rising
    task automatic t_fifo;
        wr(A + 16'h3, 8'h02);
        for (int i = 0; i < 17; i++)
            hs_peer_inst.send(8'h40 + 8'(i), 3);
        chk("ready", 8'h00, {7'h0, rx_ready_o});
        for (int i = 0; i < 16; i++)
            rc(A, "fifo", 8'h40 + 8'(i));
        chk("ready", 8'h01, {7'h0, rx_ready_o});
        rc(A, "live", 8'hff);
    endtask : t_fifo
    task automatic t_loop;
        wr(A + 16'h3, 8'h12);
        rc(A + 16'h3, "test", 8'hd2);
        wr(A + 16'h3, 8'h10);
        chk("hso", 8'h00, {7'h0, handshake_out});
        repeat (4) @(negedge mclk_i);
        rc(A + 16'h3, "loop", 8'h90);
    endtask : t_loop
    initial begin
        repeat (10) @(negedge mclk_i);
        rst_i = 1'b0;
        t_reset();
        t_dir();
        t_falling();
        t_rising();
        t_fifo();
        t_loop();
        end_of_test();
    end
endmodule : hs_parallel_port_tb_top
bind hs_parallel_port hs_port_assertions #(.INSTANCE(INSTANCE))
    hs_port_assertions_inst (
    .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pio_o,
    .pio_oe_o, .handshake_in_i, .handshake_out_o, .irq_o);
`default_nettype wire
